// [uart_channel.sv]
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module uart_channel
  import feature_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       wr_en,
  input  wire logic [6:0] wr_ofs,
  input  wire logic [7:0] wr_data,
  input  wire logic [6:0] rd_ofs,
  input  wire logic       rx_sync,
  input  wire logic [3:0] modem_in,
  input  wire logic       sleep_req,
  input  wire logic       tx_below,
  input  wire logic       tx_empty,
  input  wire logic       tsr_idle,
  output logic [7:0]      rd_data,
  output logic            tx_out,
  output logic            op2_out,
  output logic            rts_out,
  output logic            dtr_out,
  output logic            irq_oe_n,
  output logic            irq_out
);
  // -----------------------------------------------------------------------
  // registers of one channel
  // -----------------------------------------------------------------------
  typedef enum logic [1:0] {
    run_st   = 2'b00,
    sleep_st = 2'b01,
    rst_st   = 2'b10
  } chan_e;
  chan_e      state;
  chan_e      next_state;
  logic [7:0] interrupt_enable_reg, fifo_control_reg, interrupt_status_reg, line_control_reg, modem_control_reg, line_status_reg, extra_fifo_control_reg, enhanced_feature_reg, scratch_reg;
  logic [7:0] txcnt, rxcnt, txlvl, rxlvl, flwh, flwl, pres, turn;
  logic [7:0] afc2, afc1;
  logic [3:0] msr_lo;
  logic [3:0] modem_q;
  logic       rx_q;
  logic [2:0] rst_cnt;
  logic       tx_irq;
  logic [2:0] warm;
  // soft restart loads the same register and pin values as the pin, except that modem_q takes the modem pins instead of zero
  wire soft_rst = (state == rst_st);
  wire srst_req = wr_en && wr_ofs == ofs_afc1 && wr_data[bit_srst];
  wire we_ok    = wr_en && !soft_rst;
  // rts/cts or dtr/dsr selection for hardware flow control
  wire cts_line = modem_in[0];
  wire dsr_line = modem_in[1];
  wire flow_in  = afc1[bit_remap] ? dsr_line : cts_line;
  // wake and sleep gating
  wire rx_edge  = rx_sync != rx_q;
  // modem change detect, held off while the pin synchroniser fills
  wire [3:0] mdm_chg = (&warm) ? (modem_in ^ modem_q) : 4'h0;
  wire can_sleep = afc1[bit_rxedge] ? 1'b1 : rx_sync;
  wire wake = afc1[bit_rxedge] ? rx_edge : !rx_sync;
  // tx empty interrupt timing
  wire empty_ok = afc1[bit_tsrmode] ? (tx_empty && tsr_idle)
                                    : tx_empty;
  wire next_irq = tx_below || empty_ok;

  // -----------------------------------------------------------------------
  // channel state machine
  // -----------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      run_st: begin
        if (srst_req)
          next_state = rst_st;
        else if (sleep_req && can_sleep)
          next_state = sleep_st;
      end
      sleep_st: begin
        if (srst_req)
          next_state = rst_st;
        else if (wake)
          next_state = run_st;
      end
      rst_st: begin
        if (rst_cnt == 3'h0)
          next_state = run_st;
      end
      default: next_state = run_st;
    endcase
  end

  // state and restart counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state   <= run_st;
      rst_cnt <= 3'h0;
      rx_q    <= 1'b1;
      warm    <= 3'h0;
    end else begin
      state   <= next_state;
      warm    <= warm + {2'h0, ~&warm};
      rx_q    <= rx_sync;
      rst_cnt <= srst_req ? srst_len
                          : (rst_cnt != 3'h0 ? rst_cnt - 3'h1 : 3'h0);
    end
  end

  // register file, cleared by pin or soft restart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {interrupt_enable_reg, fifo_control_reg, interrupt_status_reg, line_control_reg, modem_control_reg, line_status_reg, extra_fifo_control_reg, enhanced_feature_reg} <= '0;
      interrupt_status_reg <= rst_isr;
      line_status_reg <= rst_lsr;
      scratch_reg <= rst_spr;
      {txcnt, rxcnt, txlvl, rxlvl, flwh, flwl, pres, turn} <= '0;
      afc2 <= rst_zero;
      afc1 <= rst_zero;
      msr_lo  <= rst_msr_lo;
      modem_q <= 4'h0;
      tx_irq  <= 1'b0;
    end else if (soft_rst) begin
      {interrupt_enable_reg, fifo_control_reg, line_control_reg, modem_control_reg, extra_fifo_control_reg, enhanced_feature_reg} <= '0;
      interrupt_status_reg <= rst_isr;
      line_status_reg <= rst_lsr;
      scratch_reg <= rst_spr;
      {txcnt, rxcnt, txlvl, rxlvl, flwh, flwl, pres, turn} <= '0;
      afc2 <= rst_zero;
      afc1 <= rst_zero;
      msr_lo  <= rst_msr_lo;
      modem_q <= modem_in;
      tx_irq  <= 1'b0;
    end else begin
      modem_q <= modem_in;
      msr_lo  <= msr_lo | mdm_chg;
      tx_irq  <= next_irq && interrupt_enable_reg[1];
      interrupt_status_reg     <= {7'h0, !(next_irq && interrupt_enable_reg[1])};
      line_status_reg     <= {1'b0, tx_empty && tsr_idle, tx_empty, 5'h0};
      if (we_ok) begin
        case (wr_ofs)
          ofs_ier:   interrupt_enable_reg   <= wr_data;
          ofs_fcr:   fifo_control_reg   <= wr_data;
          ofs_lcr:   line_control_reg   <= wr_data;
          ofs_mcr:   modem_control_reg   <= wr_data;
          ofs_spr:   scratch_reg   <= wr_data;
          ofs_extra_fifo_control_reg:  extra_fifo_control_reg  <= wr_data;
          ofs_efr:   enhanced_feature_reg   <= wr_data;
          ofs_txlvl: txlvl <= wr_data;
          ofs_rxlvl: rxlvl <= wr_data;
          ofs_flwh:  flwh  <= wr_data;
          ofs_flwl:  flwl  <= wr_data;
          ofs_pres:  pres  <= wr_data & pres_wmask;
          ofs_turn:  turn  <= wr_data;
          ofs_afc2:  afc2  <= wr_data & afc2_wmask;
          ofs_afc1:  afc1  <= wr_data & afc1_wmask;
          ofs_msr:   msr_lo <= mdm_chg; // a fresh change beats the clear
          default: ;
        endcase
      end
    end
  end

  // pins: idle high after reset, interrupt floated until enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_out   <= 1'b1;
      op2_out  <= 1'b1;
      rts_out  <= 1'b1;
      dtr_out  <= 1'b1;
      irq_oe_n <= 1'b1;
      irq_out  <= 1'b0;
    end else if (soft_rst) begin
      tx_out   <= 1'b1;
      op2_out  <= 1'b1;
      rts_out  <= 1'b1;
      dtr_out  <= 1'b1;
      irq_oe_n <= 1'b1;
      irq_out  <= 1'b0;
    end else begin
      tx_out   <= 1'b1;
      op2_out  <= !modem_control_reg[3];
      rts_out  <= afc1[bit_remap] ? !modem_control_reg[1] : (!modem_control_reg[1] || flow_in);
      dtr_out  <= afc1[bit_remap] ? (!modem_control_reg[0] || flow_in) : !modem_control_reg[0];
      irq_oe_n <= !modem_control_reg[3];
      irq_out  <= tx_irq;
    end
  end

  // read mux, block-local
  always_comb begin
    case (rd_ofs)
      ofs_ier:   rd_data = interrupt_enable_reg;
      ofs_fcr:   rd_data = fifo_control_reg;
      ofs_isr:   rd_data = interrupt_status_reg;
      ofs_lcr:   rd_data = line_control_reg;
      ofs_mcr:   rd_data = modem_control_reg;
      ofs_lsr:   rd_data = line_status_reg;
      ofs_msr:   rd_data = {modem_q, msr_lo};
      ofs_spr:   rd_data = scratch_reg;
      ofs_extra_fifo_control_reg:  rd_data = extra_fifo_control_reg;
      ofs_efr:   rd_data = enhanced_feature_reg;
      ofs_txcnt: rd_data = txcnt;
      ofs_rxcnt: rd_data = rxcnt;
      ofs_txlvl: rd_data = txlvl;
      ofs_rxlvl: rd_data = rxlvl;
      ofs_flwh:  rd_data = flwh;
      ofs_flwl:  rd_data = flwl;
      ofs_pres:  rd_data = pres;
      ofs_turn:  rd_data = turn;
      ofs_afc2:  rd_data = afc2;
      ofs_afc1:  rd_data = afc1;
      ofs_stat:  rd_data = {5'h0, flow_in, tx_irq, state == sleep_st};
      default:   rd_data = 8'h00;
    endcase
  end
endmodule
`default_nettype wire

// [feature_pkg.sv]
// -----------------------------------------------------------------------
// feature control package
// -----------------------------------------------------------------------
// How it works
// - broadcast bit writes same register in all channels
// - level wake: no sleep while rx low
// - edge wake: sleep allowed, wake on toggle
// - remap bit moves flow control to dtr/dsr
// - soft restart bit resets channel, self-clears
// - reset completes within four clock cycles
// - mode zero: tx irq on below-trigger or empty
// - mode one: empty waits for last stop bit
// - pin reset and soft reset load the same values, except msr upper nibble (pins, not zero)
// - isr reads 01, control registers read zero
// - lsr reads 60 after reset
// - msr upper nibble follows pins, lower cleared
// - tx, op2, rts, dtr high; irq tristated
`default_nettype none
package feature_pkg;
  // ---------------------------------------------------------------------
  // register map, per channel block of 0x80 bytes
  // ---------------------------------------------------------------------
  localparam logic [7:0] ch_stride_bit = 8'h80; // addr bit 7 picks channel
  localparam logic [6:0] ofs_ier   = 7'h00;
  localparam logic [6:0] ofs_fcr   = 7'h04;
  localparam logic [6:0] ofs_isr   = 7'h08;
  localparam logic [6:0] ofs_lcr   = 7'h0c;
  localparam logic [6:0] ofs_mcr   = 7'h10;
  localparam logic [6:0] ofs_lsr   = 7'h14;
  localparam logic [6:0] ofs_msr   = 7'h18;
  localparam logic [6:0] ofs_spr   = 7'h1c;
  localparam logic [6:0] ofs_extra_fifo_control_reg  = 7'h20;
  localparam logic [6:0] ofs_efr   = 7'h24;
  localparam logic [6:0] ofs_txcnt = 7'h28;
  localparam logic [6:0] ofs_rxcnt = 7'h2c;
  localparam logic [6:0] ofs_txlvl = 7'h30;
  localparam logic [6:0] ofs_rxlvl = 7'h34;
  localparam logic [6:0] ofs_flwh  = 7'h38;
  localparam logic [6:0] ofs_flwl  = 7'h3c;
  localparam logic [6:0] ofs_pres  = 7'h40;
  localparam logic [6:0] ofs_turn  = 7'h44;
  localparam logic [6:0] ofs_afc2  = 7'h48;
  localparam logic [6:0] ofs_afc1  = 7'h4c;
  localparam logic [6:0] ofs_stat  = 7'h50; // channel side status
  // ---------------------------------------------------------------------
  // field positions of extended_feature_control
  // ---------------------------------------------------------------------
  localparam int bit_bcast  = 7;
  localparam int bit_rxedge = 4;
  localparam int bit_remap  = 2;
  localparam int bit_srst   = 1;
  localparam int bit_tsrmode = 0;
  localparam logic [7:0] afc1_wmask = 8'h97; // reserved 6,5,3 dropped
  localparam logic [7:0] afc2_wmask = 8'h3f;
  localparam logic [7:0] pres_wmask = 8'h0f;
  // status register fields
  localparam int st_asleep = 0;
  localparam int st_txirq  = 1;
  localparam int st_flow   = 2;
  // ---------------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------------
  localparam logic [7:0] rst_zero = 8'h00;
  localparam logic [7:0] rst_isr  = 8'h01;
  localparam logic [7:0] rst_lsr  = 8'h60;
  localparam logic [7:0] rst_spr  = 8'hff;
  localparam logic [3:0] rst_msr_lo = 4'h0;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int reset_clocks = 4; // cycles a soft restart lasts
  localparam logic [2:0] srst_len = 3'(reset_clocks - 1);
endpackage
`default_nettype wire

// [uart_feature_control_and_reset.sv]
`timescale 1ns/10ps
`default_nettype none
module uart_feature_control_and_reset
  import feature_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  serial_receive_inputs,
  input  wire logic [7:0]  modem_pins,
  input  wire logic [1:0]  sleep_req,
  input  wire logic [1:0]  tx_below,
  input  wire logic [1:0]  tx_empty,
  input  wire logic [1:0]  tsr_idle,
  output logic [1:0]       serial_transmit_outputs,
  output logic [1:0]       general_output_two,
  output logic [1:0]       request_to_send_outputs,
  output logic [1:0]       terminal_ready_outputs,
  output logic [1:0]       interrupt_outputs,
  output logic [1:0]       interrupt_oe_n
);
  // -----------------------------------------------------------------------
  // bus decode
  // -----------------------------------------------------------------------
  wire        access  = psel && penable;
  wire        wr_go   = access && pwrite && paddr[1:0] == 2'b00;
  wire        ch_sel  = paddr[7];
  wire [6:0]  ofs     = paddr[6:0];
  wire [1:0]  bcast;
  wire [7:0]  rd_ch [2];
  wire [1:0]  ch_tx, ch_op2, ch_rts, ch_dtr, ch_irq, ch_oe;
  wire  [1:0] bc_on;
  logic [1:0] rx_s0, rx_s1, rx_s2, rx_stable;
  logic [7:0] md_s0, md_s1, md_s2, md_stable;

  // rx pins: three-stage sync, change accepted when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s0     <= 2'h3;
      rx_s1     <= 2'h3;
      rx_s2     <= 2'h3;
      rx_stable <= 2'h3;
      md_s0     <= 8'h00;
      md_s1     <= 8'h00;
      md_s2     <= 8'h00;
      md_stable <= 8'h00;
    end else begin
      rx_s0     <= serial_receive_inputs;
      rx_s1     <= rx_s0;
      rx_s2     <= rx_s1;
      rx_stable <= (~(rx_s1 ^ rx_s2) & rx_s2) | ((rx_s1 ^ rx_s2) & rx_stable);
      md_s0     <= modem_pins;
      md_s1     <= md_s0;
      md_s2     <= md_s1;
      md_stable <= (~(md_s1 ^ md_s2) & md_s2) | ((md_s1 ^ md_s2) & md_stable);
    end
  end

  // -----------------------------------------------------------------------
  // channels
  // -----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : ch
      logic [7:0] rd_q;
      // write reaches every channel while the addressed one broadcasts
      assign bc_on[g] = rd_q[bit_bcast];
      assign bcast[g] = wr_go && (ch_sel == 1'(g) || bc_on[ch_sel]);
      uart_channel u_chan (
        .pclk      (pclk),
        .presetn   (presetn),
        .wr_en     (bcast[g]),
        .wr_ofs    (ofs),
        .wr_data   (pwdata[7:0]),
        .rd_ofs    (ofs),
        .rx_sync   (rx_stable[g]),
        .modem_in  (md_stable[4*g +: 4]),
        .sleep_req (sleep_req[g]),
        .tx_below  (tx_below[g]),
        .tx_empty  (tx_empty[g]),
        .tsr_idle  (tsr_idle[g]),
        .rd_data   (rd_ch[g]),
        .tx_out    (ch_tx[g]),
        .op2_out   (ch_op2[g]),
        .rts_out   (ch_rts[g]),
        .dtr_out   (ch_dtr[g]),
        .irq_oe_n  (ch_oe[g]),
        .irq_out   (ch_irq[g])
      );
      // shadow of the feature register; a restart write clears it as well
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          rd_q <= 8'h00;
        else if (bcast[g] && ofs == ofs_afc1)
          rd_q <= pwdata[bit_srst] ? 8'h00 : (pwdata[7:0] & afc1_wmask);
      end
    end
  endgenerate

  // bus answer and pin registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      serial_transmit_outputs <= 2'h3;
      general_output_two      <= 2'h3;
      request_to_send_outputs <= 2'h3;
      terminal_ready_outputs  <= 2'h3;
      interrupt_outputs       <= 2'h0;
      interrupt_oe_n          <= 2'h3;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && paddr[1:0] != 2'b00;
      prdata  <= {24'h0, rd_ch[ch_sel]};
      serial_transmit_outputs <= ch_tx;
      general_output_two      <= ch_op2;
      request_to_send_outputs <= ch_rts;
      terminal_ready_outputs  <= ch_dtr;
      interrupt_outputs       <= ch_irq;
      interrupt_oe_n          <= ch_oe;
    end
  end
endmodule
`default_nettype wire

// [feature_monitor.sv]
`timescale 1ns/10ps
`default_nettype none
module feature_monitor
  import feature_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [1:0]  serial_transmit_outputs,
  input wire logic [1:0]  general_output_two,
  input wire logic [1:0]  request_to_send_outputs,
  input wire logic [1:0]  terminal_ready_outputs,
  input wire logic [1:0]  interrupt_oe_n
);
  // ---------------------------------------------------------------------
  // bus and reset checks
  // ---------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // setup phase of any transfer
  sequence setup_s;
    psel && !penable;
  endsequence
  // accepted write of the restart bit on channel zero
  sequence srst_s;
    psel && penable && pready && pwrite && paddr == {1'b0, ofs_afc1}
      && pwdata[bit_srst];
  endsequence
  // channel zero pins at their idle level
  sequence pins_hi_s;
    request_to_send_outputs[0] && terminal_ready_outputs[0]
      && serial_transmit_outputs[0] && general_output_two[0];
  endsequence
  pready_setup_a: assert property (setup_s |=> pready)
    else $error("no pready after setup");
  pready_pulse_a: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  pready_idle_a: assert property (!psel |=> !pready)
    else $error("pready without select");
  slverr_pair_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  misalign_err_a: assert property
    (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("misaligned access not flagged");
  reserved_zero_a: assert property (psel && !penable && !pwrite &&
    paddr[6:0] == ofs_afc1 |=> prdata[6:5] == 2'h0 && !prdata[3])
    else $error("reserved feature bits read nonzero");
  reset_pins_a: assert property ($rose(presetn) |->
    (serial_transmit_outputs & general_output_two & interrupt_oe_n
     & request_to_send_outputs & terminal_ready_outputs) == 2'h3)
    else $error("pins not at reset level");
  srst_pins_a: assert property (srst_s |-> ##3 pins_hi_s [*3])
    else $error("soft restart pins not held");
endmodule
bind uart_feature_control_and_reset feature_monitor i_feature_monitor (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .serial_transmit_outputs, .general_output_two,
  .request_to_send_outputs, .terminal_ready_outputs, .interrupt_oe_n);
`default_nettype wire

// [apb_host.sv]
`timescale 1ns/10ps
`default_nettype none
module apb_host (
  input wire logic   pclk,
  input wire logic   pready,
  output logic       psel,
  output logic       penable,
  output logic       pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  // idle bus from time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // one transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule
`default_nettype wire

// [uart_feature_control_and_reset_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module uart_feature_control_and_reset_tb
  import feature_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, mdm, v;
  logic [31:0] pwdata, prdata;
  logic [1:0]  rxi, slp, below, empty, idle, txo, op2, rts, dtr, irq, ioe;
  logic [24:0] n;
  logic [24:0] expq[$];
  logic [1:0]  p;
  int          err_total, comparisons, cyc;
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  apb_host i_apb_host (.pclk, .pready, .psel, .penable, .pwrite, .paddr,
    .pwdata);
  uart_feature_control_and_reset i_uart_feature_control_and_reset (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .serial_receive_inputs(rxi), .modem_pins(mdm),
    .sleep_req(slp), .tx_below(below), .tx_empty(empty), .tsr_idle(idle),
    .serial_transmit_outputs(txo), .general_output_two(op2),
    .request_to_send_outputs(rts), .terminal_ready_outputs(dtr),
    .interrupt_outputs(irq), .interrupt_oe_n(ioe));
  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [7:0] a, input logic [8:0] seen,
                     input logic [8:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] reg %h exp %h seen %h", a, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] m,
                    input logic [7:0] x, input logic e = 1'b0);
    expq.push_back({a, e, m, x});
    i_apb_host.xfer(1'b0, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_apb_host.xfer(1'b1, a, d);
  endtask
  task automatic test_done;
    $display("compares %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // expected reset value of one register offset
  function automatic logic [7:0] rst_of(input int o, input int c);
    case (o)
      ofs_isr: return rst_isr;
      ofs_lsr: return rst_lsr;
      ofs_msr: return {mdm[4*c +: 4], rst_msr_lo};
      ofs_spr: return rst_spr;
      ofs_stat: return {5'h0, mdm[4*c], 2'b00};
      default: return rst_zero;
    endcase
  endfunction
  // read checker: oldest note against the answer
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      n = expq.pop_front();
      chk(n[24:17], {pslverr, prdata[7:0] & n[15:8]}, {n[16], n[7:0]});
    end
  end
  // hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_total++;
      test_done();
    end
  end
  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    rxi = 2'h3;
    slp = 2'h0;
    below = 2'h0;
    empty = 2'h3;
    idle = 2'h3;
    void'($urandom(32'h8a65));
    mdm = 8'($urandom);
    repeat (12) @(posedge pclk);
    chk(8'h00, {1'b0, op2, rts, dtr, ioe}, 9'h0ff);
    chk(8'h00, {7'h0, txo}, 9'h003);
    presetn <= 1'b1;
    for (int c = 0; c < 2; c++)
      for (int o = 0; o < 128; o += 4)
        rd(8'(c * 128 + o), 8'hff, rst_of(o, c));
    rd(8'h01, 8'h00, 8'h00, 1'b1);
    wr(8'h4c, 8'h79);
    rd(8'h4c, 8'hff, 8'h11);
    $display("test reset_values done");
    v = 8'($urandom);
    wr(8'h4c, 8'h80);
    wr(8'h1c, v);
    rd(8'h9c, 8'hff, v);
    wr(8'h4c, 8'h00);
    wr(8'h1c, ~v);
    rd(8'h9c, 8'hff, v);
    rd(8'h1c, 8'hff, ~v);
    $display("test broadcast done");
    for (int s = 0; s < 2; s++) begin
      wr(8'h0c, 8'h03);
      wr(8'h10, 8'h0b);
      wr(8'h1c, 8'h5a);
      if (s == 0) wr(8'h4c, 8'h02);
      else begin
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
      end
      repeat (reset_clocks) @(posedge pclk);
      rd(8'h4c, 8'hff, rst_zero);
      rd(8'h0c, 8'hff, rst_zero);
      rd(8'h1c, 8'hff, rst_spr);
      rd(8'h10, 8'hff, rst_zero);
      chk(8'h10, {1'b0, op2, rts, dtr, ioe}, 9'h0ff);
    end
    $display("test restart done");
    slp[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(8'h50, 8'h01, 8'h01);
    rxi[0] <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(8'h50, 8'h01, 8'h00);
    wr(8'h4c, 8'h10);
    repeat (10) @(posedge pclk);
    rd(8'h50, 8'h01, 8'h01);
    slp[0] <= 1'b0;
    repeat (10) @(posedge pclk);
    rd(8'h50, 8'h01, 8'h01);
    rxi[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    rd(8'h50, 8'h01, 8'h00);
    $display("test sleep done");
    wr(8'h10, 8'h03);
    for (int r = 0; r < 4; r++) begin
      p = r[0] ? 2'b10 : 2'b01;
      mdm[1:0] <= p;
      wr(8'h4c, {5'h0, r[1], 2'b0});
      repeat (6) @(posedge pclk);
      rd(8'h50, 8'h04, {5'h0, r[1] ? p[1] : p[0], 2'b0});
      chk(8'h10, {7'h0, rts[0], dtr[0]},
          {7'h0, r[1] ? 1'b0 : p[0], r[1] ? p[1] : 1'b0});
    end
    $display("test flow_remap done");
    wr(8'h00, 8'h02);
    for (int k = 0; k < 16; k++) begin
      below[0] <= k[2];
      empty[0] <= k[1];
      idle[0] <= k[0];
      wr(8'h4c, {7'h0, k[3]});
      repeat (3) @(posedge pclk);
      rd(8'h50, 8'h02, {6'h0, k[2] | k[1] & (!k[3] | k[0]), 1'b0});
      chk(8'h50, {8'h0, irq[0]}, {8'h0, k[2] | k[1] & (!k[3] | k[0])});
    end
    $display("test tx_irq done");
    @(posedge pclk);
    test_done();
  end
endmodule
`default_nettype wire
